/* awc_regs.v */
// alarm window registers, extreme capture registers and threshold crossing detection
//
// Overview of operation
// [R1] pressure window 16 bits at 19h/1Ah
// [R2] temperature window 8 bits at 1Bh
// [R3] lowest pressure 20 bits at 1Ch-1Eh
// [R4] 18 integer bits, two fraction bits
// [R5] highest pressure at 21h-23h, same layout
// [R6] lowest pressure zero at power-up, write-zero clears
// [R7] highest pressure clears likewise
// [R8] lowest temperature 12-bit signed at 1Fh/20h
// [R9] temperature fraction bits 7:4, 3:0 reserved
// [R10] lowest temperature clears at power-up, write-zero
// [R11] pressure window around target forms thresholds
// [R12] zero window: centre only; else all three
// [R13] track min/max; first sample after clear loads
// [R14] reserved low bits ignore writes, read zero
`timescale 1ns/1ps
`include "awc_defs.vh"

module awc_regs (
  input  wire        i_ref_clk,
  input  wire        i_resetn,
  // byte register port from the serial interface engine
  input  wire [7:0]  i_reg_addr,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  input  wire [7:0]  i_reg_wdata,
  output reg  [7:0]  o_reg_rdata,
  // measurement stream
  input  wire        i_pres_valid,
  input  wire [19:0] i_pres_sample,        // pascals, bits 1:0 fraction
  input  wire        i_temp_valid,
  input  wire [11:0] i_temp_sample,        // signed degrees, bits 3:0 fraction
  // targets held in the neighbouring register group
  input  wire [15:0] i_pressure_target_value, // two-pascal units
  input  wire [7:0]  i_temp_target,        // signed degrees
  // results
  output reg         o_pres_thresh_evt,
  output reg         o_temperature_threshold_source_flag,
  output reg  [15:0] o_pres_window,
  output reg  [7:0]  o_temp_window
);

  // window registers
  reg  [7:0]  pwin_high_ff;                // window bits 15:8
  reg  [7:0]  pwin_low_ff;                 // window bits 7:0
  reg  [7:0]  twin_ff;
  wire [15:0] pwin;

  // capture values
  wire [19:0] pmin;
  wire [19:0] pmax;
  wire [11:0] tmin;

  // decoded write strobes and byte merge
  wire        wr_pminh;
  wire        wr_pminm;
  wire        wr_pminl;
  wire        wr_pmaxh;
  wire        wr_pmaxm;
  wire        wr_pmaxl;
  wire        wr_tminh;
  wire        wr_tminl;
  wire        pmin_any;
  wire        pmax_any;
  wire        tmin_any;
  wire        wzero_full;                  // full byte written is zero
  wire        wzero_field;                 // data bits 7:4 written are zero
  reg         pmin_zero;
  reg         pmax_zero;
  reg         tmin_zero;
  reg  [19:0] pmin_merge;
  reg  [19:0] pmax_merge;
  reg  [11:0] tmin_merge;

  assign pwin        = {pwin_high_ff, pwin_low_ff}; // R1
  assign wzero_full  = (i_reg_wdata == 8'h00);
  // reserved bits do not count, so 0x0f into a low byte still clears
  assign wzero_field = (i_reg_wdata[`AWC_LOW_FIELD_HI:`AWC_LOW_FIELD_LO] == 4'h0); // R14

  assign wr_pminh = i_reg_wr && (i_reg_addr == `AWC_OFS_LOWEST_PRESSURE_HIGH);    // R3
  assign wr_pminm = i_reg_wr && (i_reg_addr == `AWC_OFS_LOWEST_PRESSURE_MID);     // R3
  assign wr_pminl = i_reg_wr && (i_reg_addr == `AWC_OFS_LOWEST_PRESSURE_LOW);     // R3
  assign wr_pmaxh = i_reg_wr && (i_reg_addr == `AWC_OFS_HIGHEST_PRESSURE_HIGH);   // R5
  assign wr_pmaxm = i_reg_wr && (i_reg_addr == `AWC_OFS_HIGHEST_PRESSURE_MID);    // R5
  assign wr_pmaxl = i_reg_wr && (i_reg_addr == `AWC_OFS_HIGHEST_PRESSURE_LOW);    // R5
  assign wr_tminh = i_reg_wr && (i_reg_addr == `AWC_OFS_LOWEST_TEMPERATURE_HIGH); // R8
  assign wr_tminl = i_reg_wr && (i_reg_addr == `AWC_OFS_LOWEST_TEMPERATURE_LOW);  // R8
  assign pmin_any = wr_pminh | wr_pminm | wr_pminl;
  assign pmax_any = wr_pmaxh | wr_pmaxm | wr_pmaxl;
  assign tmin_any = wr_tminh | wr_tminl;

  // merge the written byte into the capture; low bytes keep only bits 7:4
  always @* begin
    pmin_merge = pmin;
    pmax_merge = pmax;
    tmin_merge = tmin;
    if (wr_pminh) begin
      pmin_merge[19:12] = i_reg_wdata;                  // R4
    end else if (wr_pminm) begin
      pmin_merge[11:4] = i_reg_wdata;                   // R4
    end else if (wr_pminl) begin
      pmin_merge[3:0] = i_reg_wdata[7:4];               // R4 R14
    end
    if (wr_pmaxh) begin
      pmax_merge[19:12] = i_reg_wdata;                  // R5
    end else if (wr_pmaxm) begin
      pmax_merge[11:4] = i_reg_wdata;                   // R5
    end else if (wr_pmaxl) begin
      pmax_merge[3:0] = i_reg_wdata[7:4];               // R5 R14
    end
    if (wr_tminh) begin
      tmin_merge[11:4] = i_reg_wdata;                   // R8
    end else if (wr_tminl) begin
      tmin_merge[3:0] = i_reg_wdata[7:4];               // R9 R14
    end
  end

  // a zero write into any byte of a group clears the whole capture
  always @* begin
    pmin_zero = pmin_any && (wr_pminl ? wzero_field : wzero_full); // R6
    pmax_zero = pmax_any && (wr_pmaxl ? wzero_field : wzero_full); // R7
    tmin_zero = tmin_any && (wr_tminl ? wzero_field : wzero_full); // R10
  end

  // lowest pressure, unsigned
  awc_extreme #(
    .W       (`AWC_PCAP_W),
    .SIGNED  (0),
    .MAXMODE (0)
  ) u_pmin (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_clear   (pmin_zero),
    .i_wr_en   (pmin_any & ~pmin_zero),
    .i_wr_val  (pmin_merge),
    .i_valid   (i_pres_valid),
    .i_sample  (i_pres_sample),
    .o_value   (pmin)
  );

  // highest pressure, unsigned
  awc_extreme #(
    .W       (`AWC_PCAP_W),
    .SIGNED  (0),
    .MAXMODE (1)
  ) u_pmax (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_clear   (pmax_zero),
    .i_wr_en   (pmax_any & ~pmax_zero),
    .i_wr_val  (pmax_merge),
    .i_valid   (i_pres_valid),
    .i_sample  (i_pres_sample),
    .o_value   (pmax)
  );

  // lowest temperature, two's complement
  awc_extreme #(
    .W       (`AWC_TCAP_W),
    .SIGNED  (1),
    .MAXMODE (0)
  ) u_tmin (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_clear   (tmin_zero),
    .i_wr_en   (tmin_any & ~tmin_zero),
    .i_wr_val  (tmin_merge),
    .i_valid   (i_temp_valid),
    .i_sample  (i_temp_sample),
    .o_value   (tmin)
  );

  // window registers, plain read-write bytes
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pwin_high_ff <= `AWC_RST_BYTE;                    // R1
      pwin_low_ff  <= `AWC_RST_BYTE;                    // R1
      twin_ff      <= `AWC_RST_BYTE;                    // R2
    end else if (i_reg_wr) begin
      if (i_reg_addr == `AWC_OFS_PRESSURE_WINDOW_HIGH) begin
        pwin_high_ff <= i_reg_wdata;                    // R1
      end
      if (i_reg_addr == `AWC_OFS_PRESSURE_WINDOW_LOW) begin
        pwin_low_ff <= i_reg_wdata;                     // R1
      end
      if (i_reg_addr == `AWC_OFS_TEMPERATURE_WINDOW) begin
        twin_ff <= i_reg_wdata;                         // R2
      end
    end
  end

  // read mux; reserved low bits always zero, unmapped offsets read 00h
  reg [7:0] nxt_rdata;
  always @* begin
    case (i_reg_addr)
      `AWC_OFS_PRESSURE_WINDOW_HIGH:    nxt_rdata = pwin_high_ff;
      `AWC_OFS_PRESSURE_WINDOW_LOW:     nxt_rdata = pwin_low_ff;
      `AWC_OFS_TEMPERATURE_WINDOW:      nxt_rdata = twin_ff;
      `AWC_OFS_LOWEST_PRESSURE_HIGH:    nxt_rdata = pmin[19:12];
      `AWC_OFS_LOWEST_PRESSURE_MID:     nxt_rdata = pmin[11:4];
      `AWC_OFS_LOWEST_PRESSURE_LOW:     nxt_rdata = {pmin[3:0], `AWC_LOW_RSVD}; // R4 R14
      `AWC_OFS_LOWEST_TEMPERATURE_HIGH: nxt_rdata = tmin[11:4];
      `AWC_OFS_LOWEST_TEMPERATURE_LOW:  nxt_rdata = {tmin[3:0], `AWC_LOW_RSVD}; // R9 R14
      `AWC_OFS_HIGHEST_PRESSURE_HIGH:   nxt_rdata = pmax[19:12];
      `AWC_OFS_HIGHEST_PRESSURE_MID:    nxt_rdata = pmax[11:4];
      `AWC_OFS_HIGHEST_PRESSURE_LOW:    nxt_rdata = {pmax[3:0], `AWC_LOW_RSVD}; // R5 R14
      default:                          nxt_rdata = 8'h00;
    endcase
  end

  // read data is registered: valid the cycle after the read strobe
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= nxt_rdata;
    end
  end

  // pressure thresholds, compared in pascals on the integer part
  // target and window are two-pascal units, so both are doubled to 17 bits;
  // lower threshold clamps at zero, upper is one bit wider and never wraps
  wire [18:0] p_ctr;
  wire [18:0] p_up;
  wire [18:0] p_lo;
  wire [18:0] p_int;
  wire [2:0]  p_above;                     // {>=upper, >=centre, >=lower}
  wire [2:0]  p_mask;
  reg  [2:0]  p_prev_ff;
  reg         p_seen_ff;                   // a previous sample exists

  assign p_ctr   = {2'b00, i_pressure_target_value, 1'b0};                  // R11
  assign p_up    = p_ctr + {2'b00, pwin, 1'b0};                             // R11
  assign p_lo    = (p_ctr > {2'b00, pwin, 1'b0}) ? (p_ctr - {2'b00, pwin, 1'b0}) : 19'h00000; // R11
  assign p_int   = {1'b0, i_pres_sample[19:2]};                             // R4
  assign p_above = {(p_int >= p_up), (p_int >= p_ctr), (p_int >= p_lo)};
  assign p_mask  = (pwin == 16'h0000) ? 3'b010 : 3'b111;                    // R12

  // a crossing is a change of side of any active threshold between samples
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      p_prev_ff         <= 3'b000;
      p_seen_ff         <= 1'b0;
      o_pres_thresh_evt <= 1'b0;
    end else begin
      o_pres_thresh_evt <= 1'b0;
      if (i_pres_valid) begin
        p_prev_ff         <= p_above;
        p_seen_ff         <= 1'b1;
        o_pres_thresh_evt <= p_seen_ff && (|((p_above ^ p_prev_ff) & p_mask)); // R12
      end
    end
  end

  // temperature thresholds, signed whole degrees
  // ten bits hold target plus or minus window without overflow
  wire signed [9:0] t_ctr;
  wire signed [9:0] temperature_window;
  wire signed [9:0] t_up;
  wire signed [9:0] t_lo;
  wire signed [9:0] t_int;
  wire [2:0]        t_above;
  wire [2:0]        t_mask;
  reg  [2:0]        t_prev_ff;
  reg               t_seen_ff;

  assign t_ctr   = {{2{i_temp_target[7]}}, i_temp_target};
  assign temperature_window   = {2'b00, twin_ff};
  assign t_up    = t_ctr + temperature_window;
  assign t_lo    = t_ctr - temperature_window;
  assign t_int   = {{2{i_temp_sample[11]}}, i_temp_sample[11:4]};
  assign t_above = {(t_int >= t_up), (t_int >= t_ctr), (t_int >= t_lo)};
  assign t_mask  = (twin_ff == 8'h00) ? 3'b010 : 3'b111; // R12

  // temperature crossing pulse, same scheme as pressure
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      t_prev_ff                           <= 3'b000;
      t_seen_ff                           <= 1'b0;
      o_temperature_threshold_source_flag <= 1'b0;
    end else begin
      o_temperature_threshold_source_flag <= 1'b0;
      if (i_temp_valid) begin
        t_prev_ff                           <= t_above;
        t_seen_ff                           <= 1'b1;
        o_temperature_threshold_source_flag <= t_seen_ff && (|((t_above ^ t_prev_ff) & t_mask));
      end
    end
  end

  // window values exported to the neighbouring logic from flops
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pres_window <= `AWC_RST_PWIN;
      o_temp_window <= `AWC_RST_BYTE;
    end else begin
      o_pres_window <= pwin;
      o_temp_window <= twin_ff;
    end
  end

endmodule // awc_regs

/* awc_defs.vh */
// register offsets, field layouts and reset values of the alarm window and extreme capture group
`ifndef AWC_DEFS_VH
`define AWC_DEFS_VH

// register offsets on the byte register port
`define AWC_OFS_PRESSURE_WINDOW_HIGH    8'h19
`define AWC_OFS_PRESSURE_WINDOW_LOW     8'h1a
`define AWC_OFS_TEMPERATURE_WINDOW      8'h1b
`define AWC_OFS_LOWEST_PRESSURE_HIGH    8'h1c
`define AWC_OFS_LOWEST_PRESSURE_MID     8'h1d
`define AWC_OFS_LOWEST_PRESSURE_LOW     8'h1e
`define AWC_OFS_LOWEST_TEMPERATURE_HIGH 8'h1f
`define AWC_OFS_LOWEST_TEMPERATURE_LOW  8'h20
`define AWC_OFS_HIGHEST_PRESSURE_HIGH   8'h21
`define AWC_OFS_HIGHEST_PRESSURE_MID    8'h22
`define AWC_OFS_HIGHEST_PRESSURE_LOW    8'h23

// reset values
`define AWC_RST_BYTE                    8'h00
`define AWC_RST_PWIN                    16'h0000
`define AWC_RST_PCAP                    20'h00000
`define AWC_RST_TCAP                    12'h000

// field widths
`define AWC_PCAP_W                      20
`define AWC_TCAP_W                      12
`define AWC_PWIN_W                      16
`define AWC_TWIN_W                      8

// low capture bytes: bits 7:4 carry data, bits 3:0 are reserved
`define AWC_LOW_FIELD_HI                7
`define AWC_LOW_FIELD_LO                4
`define AWC_LOW_RSVD                    4'h0

`endif

/* awc_extreme.v */
// running minimum or maximum capture with clear, host byte write and first-sample load
`timescale 1ns/1ps

module awc_extreme #(
  parameter          W       = 20,  // capture width
  parameter          SIGNED  = 0,   // 1: compare as two's complement
  parameter          MAXMODE = 0    // 1: keep highest, 0: keep lowest
) (
  input  wire         i_ref_clk,
  input  wire         i_resetn,
  input  wire         i_clear,      // host wrote zero into the group
  input  wire         i_wr_en,      // host wrote a byte whose data bits are non-zero
  input  wire [W-1:0] i_wr_val,     // capture with the written byte merged in
  input  wire         i_valid,      // new measurement sample
  input  wire [W-1:0] i_sample,
  output wire [W-1:0] o_value
);

  reg  [W-1:0] val_ff;              // captured extreme
  reg          empty_ff;            // no sample or host write since clear or power-up
  reg  [W-1:0] nxt_val;
  reg          nxt_empty;
  wire         lower;               // sample below stored value
  wire         higher;              // sample above stored value
  wire         better;

  assign lower  = SIGNED ? ($signed(i_sample) < $signed(val_ff)) : (i_sample < val_ff);
  assign higher = SIGNED ? ($signed(i_sample) > $signed(val_ff)) : (i_sample > val_ff);
  assign better = MAXMODE ? higher : lower;

  // next state: clear first, then host write, then tracking
  // a sample in the clear cycle is dropped so the cleared zero is visible to the host
  always @* begin
    nxt_val   = val_ff;
    nxt_empty = empty_ff;
    if (i_clear) begin
      nxt_val   = {W{1'b0}};          // R6 R7 R10
      nxt_empty = 1'b1;
    end else if (i_wr_en) begin
      nxt_val   = i_wr_val;           // host seeds the tracker
      nxt_empty = 1'b0;
    end else if (i_valid) begin
      if (empty_ff || better) begin
        nxt_val = i_sample;           // R13
      end
      nxt_empty = 1'b0;
    end
  end

  // capture registers, zero at power-up
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      val_ff   <= {W{1'b0}};          // R6 R7 R10
      empty_ff <= 1'b1;
    end else begin
      val_ff   <= nxt_val;
      empty_ff <= nxt_empty;
    end
  end

  assign o_value = val_ff;

endmodule // awc_extreme

/* awc_regs_chk.sv */
// concurrent checks on the ports of the alarm window and extreme capture register group
`timescale 1ns/1ps
module awc_regs_chk (
  input logic        i_ref_clk,
  input logic        i_resetn,
  input logic [7:0]  i_reg_addr,
  input logic        i_reg_wr,
  input logic        i_reg_rd,
  input logic [7:0]  i_reg_wdata,
  input logic [7:0]  o_reg_rdata,
  input logic        i_pres_valid,
  input logic        i_temp_valid,
  input logic        o_pres_thresh_evt,
  input logic        o_temperature_threshold_source_flag,
  input logic [15:0] o_pres_window,
  input logic [7:0]  o_temp_window
);
  // single clock domain, so one default clock and reset serve every property
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  // read data moves only on a read strobe, so a slow host never sees it drift
  property p_rd_hold; !i_reg_rd |=> $stable(o_reg_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed without a read");
  // offsets outside the group read as zero
  property p_unmapped; i_reg_rd && (i_reg_addr < 8'h19 || i_reg_addr > 8'h23) |=> o_reg_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped offset read non-zero");
  // reserved nibble of every low capture byte reads zero
  property p_rsvd;
    i_reg_rd && (i_reg_addr == 8'h1e || i_reg_addr == 8'h20 || i_reg_addr == 8'h23) |=> o_reg_rdata[3:0] == 4'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read non-zero");
  // window copies follow a write two edges later
  property p_pwin_hi; i_reg_wr && i_reg_addr == 8'h19 |=> ##1 o_pres_window[15:8] == $past(i_reg_wdata, 2); endproperty
  a_pwin_hi: assert property (p_pwin_hi) else $error("pressure window high byte wrong");
  property p_pwin_lo; i_reg_wr && i_reg_addr == 8'h1a |=> ##1 o_pres_window[7:0] == $past(i_reg_wdata, 2); endproperty
  a_pwin_lo: assert property (p_pwin_lo) else $error("pressure window low byte wrong");
  property p_twin; i_reg_wr && i_reg_addr == 8'h1b |=> ##1 o_temp_window == $past(i_reg_wdata, 2); endproperty
  a_twin: assert property (p_twin) else $error("temperature window wrong");
  // a crossing pulse only follows a sample
  property p_pevt; o_pres_thresh_evt |-> $past(i_pres_valid); endproperty
  a_pevt: assert property (p_pevt) else $error("pressure event without sample");
  property p_tevt; o_temperature_threshold_source_flag |-> $past(i_temp_valid); endproperty
  a_tevt: assert property (p_tevt) else $error("temperature event without sample");
endmodule // awc_regs_chk

bind awc_regs awc_regs_chk u_chk (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_pres_valid(i_pres_valid),
  .i_temp_valid(i_temp_valid), .o_pres_thresh_evt(o_pres_thresh_evt),
  .o_temperature_threshold_source_flag(o_temperature_threshold_source_flag),
  .o_pres_window(o_pres_window), .o_temp_window(o_temp_window));

/* awc_host_model.sv */
// host side model issuing byte reads and writes on the register port
`timescale 1ns/1ps
module awc_host_model (
  input  wire       i_ref_clk,
  input  wire [7:0] i_reg_rdata,
  output reg  [7:0] o_reg_addr,
  output reg        o_reg_wr,
  output reg        o_reg_rd,
  output reg  [7:0] o_reg_wdata
);
  // idle bus at time zero
  initial begin
    o_reg_addr  = 8'h00;
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    o_reg_wdata = 8'h00;
  end
  // one byte write; released lines show inverted values, not the last ones
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge i_ref_clk);
      o_reg_addr  = a;
      o_reg_wdata = d;
      o_reg_wr    = 1'b1;
      @(negedge i_ref_clk);
      o_reg_wr    = 1'b0;
      o_reg_addr  = ~a;
      o_reg_wdata = ~d;
    end
  endtask
  // one byte read; data taken after the edge that took the strobe
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(negedge i_ref_clk);
      o_reg_addr = a;
      o_reg_rd   = 1'b1;
      @(negedge i_ref_clk);
      o_reg_rd   = 1'b0;
      o_reg_addr = ~a;
      d          = i_reg_rdata;
    end
  endtask
endmodule // awc_host_model

/* awc_regs_test.sv */
// self-checking testbench for the alarm window and extreme capture register group
`timescale 1ns/1ps
module awc_regs_test;
  reg         clk, rstn, pv, tv;  // clock, reset, sample strobes
  reg  [19:0] ps;                 // pressure sample
  reg  [11:0] ts;                 // temperature sample
  reg  [15:0] ptgt;               // pressure target, two-pascal units
  reg  [7:0]  ttgt;               // temperature target
  wire [7:0]  addr, wdata, rdata, twin;
  wire        wr, rd, pevt, tevt;
  wire [15:0] pwin;
  integer     mismatches, n_checks, i;
  reg  [7:0]  d;

  awc_regs dut (.i_ref_clk(clk), .i_resetn(rstn), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_pres_valid(pv), .i_pres_sample(ps), .i_temp_valid(tv),
    .i_temp_sample(ts), .i_pressure_target_value(ptgt), .i_temp_target(ttgt), .o_pres_thresh_evt(pevt),
    .o_temperature_threshold_source_flag(tevt), .o_pres_window(pwin), .o_temp_window(twin));
  awc_host_model host (.i_ref_clk(clk), .i_reg_rdata(rdata), .o_reg_addr(addr), .o_reg_wr(wr),
    .o_reg_rd(rd), .o_reg_wdata(wdata));

  // 20 MHz clock
  always #25 clk = ~clk;

  task chk_byte(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR t=%0t byte got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task chk_bit(input got, input exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR t=%0t event got %b exp %b", $time, got, exp);
      end
    end
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    begin
      host.rd(a, d);
      chk_byte(d, e);
    end
  endtask
  // one pressure sample; the pulse is looked at in the cycle after the taking edge
  task psmp(input [19:0] v, input e);
    begin
      @(negedge clk);
      pv = 1'b1;
      ps = v;
      @(negedge clk);
      pv = 1'b0;
      ps = ~v;
      chk_bit(pevt, e);
    end
  endtask
  task tsmp(input [11:0] v, input e);
    begin
      @(negedge clk);
      tv = 1'b1;
      ts = v;
      @(negedge clk);
      tv = 1'b0;
      ts = ~v;
      chk_bit(tevt, e);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask

  // watchdog well beyond the roughly 140 cycles the tests need
  initial begin
    #250000;
    mismatches = mismatches + 1;
    $display("ERROR t=%0t watchdog expired", $time);
    print_verdict;
  end

  initial begin
    clk = 0; rstn = 0; pv = 0; tv = 0; ps = 0; ts = 0; ptgt = 16'h0100; ttgt = 8'h00;
    mismatches = 0; n_checks = 0;
    repeat (5) @(posedge clk);
    @(negedge clk) rstn = 1;
    for (i = 8'h18; i <= 8'h24; i = i + 1) rdc(i[7:0], 8'h00);
    $display("test reset values done");
    host.wr(8'h19, 8'h12);
    host.wr(8'h1a, 8'h34);
    host.wr(8'h1b, 8'h56);
    @(negedge clk);
    chk_byte(pwin[15:8], 8'h12);
    chk_byte(pwin[7:0], 8'h34);
    chk_byte(twin, 8'h56);
    rdc(8'h19, 8'h12);
    rdc(8'h1a, 8'h34);
    rdc(8'h1b, 8'h56);
    $display("test windows done");
    // wide window: every pressure sample stays above the upper threshold
    psmp(20'h12345, 1'b0);
    psmp(20'h0abcd, 1'b0);
    psmp(20'h23456, 1'b0);
    tsmp(12'h050, 1'b0);
    tsmp(12'hf8a, 1'b1);
    tsmp(12'h100, 1'b1);
    rdc(8'h1c, 8'h0a);
    rdc(8'h1d, 8'hbc);
    rdc(8'h1e, 8'hd0);
    rdc(8'h21, 8'h23);
    rdc(8'h22, 8'h45);
    rdc(8'h23, 8'h60);
    rdc(8'h1f, 8'hf8);
    rdc(8'h20, 8'ha0);
    host.wr(8'h1e, 8'hff);
    rdc(8'h1e, 8'hf0);
    host.wr(8'h20, 8'h5f);
    rdc(8'h20, 8'h50);
    $display("test capture done");
    host.wr(8'h1c, 8'h00);
    for (i = 8'h1c; i <= 8'h1e; i = i + 1) rdc(i[7:0], 8'h00);
    rdc(8'h21, 8'h23);
    host.wr(8'h23, 8'h00);
    for (i = 8'h21; i <= 8'h23; i = i + 1) rdc(i[7:0], 8'h00);
    host.wr(8'h20, 8'h0f);
    rdc(8'h1f, 8'h00);
    rdc(8'h20, 8'h00);
    psmp(20'h30000, 1'b0);
    tsmp(12'h7f0, 1'b1);
    rdc(8'h1c, 8'h30);
    rdc(8'h21, 8'h30);
    rdc(8'h1f, 8'h7f);
    $display("test clear done");
    // zero window: centre only, centre reached counts as above; then a 10h window: all three thresholds
    host.wr(8'h19, 8'h00);
    host.wr(8'h1a, 8'h00);
    psmp(20'h00400, 1'b1);
    psmp(20'h00800, 1'b1);
    psmp(20'h00c00, 1'b0);
    host.wr(8'h1a, 8'h10);
    psmp(20'h00844, 1'b1);
    psmp(20'h00848, 1'b0);
    psmp(20'h007c0, 1'b1);
    psmp(20'h00700, 1'b1);
    // moved targets shift every threshold; the old targets would give no event here
    @(negedge clk) ptgt = 16'h0080;
    psmp(20'h00400, 1'b1);
    psmp(20'h00480, 1'b1);
    @(negedge clk) ttgt = 8'h7f;
    tsmp(12'h7f0, 1'b1);
    $display("test thresholds done");
    print_verdict;
  end
endmodule // awc_regs_test
